//--- verilog/art_pkg.sv
package art_pkg;
	// Special-function register addresses
	localparam logic [7:0] ART_ADDR_CLOCK_SELECT = 8'h8E;
	localparam logic [7:0] ART_ADDR_CONTROL = 8'hC8;
	localparam logic [7:0] ART_ADDR_RELOAD_LOW = 8'hCA;
	localparam logic [7:0] ART_ADDR_RELOAD_HIGH = 8'hCB;
	localparam logic [7:0] ART_ADDR_COUNT_LOW = 8'hCC;
	localparam logic [7:0] ART_ADDR_COUNT_HIGH = 8'hCD;

	// Control register fields
	localparam int ART_BIT_HIGH_FLAG = 7;
	localparam int ART_BIT_LOW_FLAG = 6;
	localparam int ART_BIT_LOW_IRQ_EN = 5;
	localparam int ART_BIT_SPLIT = 3;
	localparam int ART_BIT_RUN = 2;
	localparam int ART_BIT_EXT_CLK = 0;
	localparam logic [7:0] ART_CONTROL_WRITE_MASK = 8'hED;

	// Clock-select register fields
	localparam int ART_BIT_HIGH_CLK_SEL = 5;
	localparam int ART_BIT_LOW_CLK_SEL = 4;

	localparam logic [7:0] ART_RESET_BYTE = 8'h00;
	localparam logic [7:0] ART_BYTE_MAX = 8'hFF;

	// Prescale ratios
	localparam int ART_CORE_DIV = 12;
	localparam int ART_EXT_DIV = 8;

	typedef struct packed {
		logic high_flag;
		logic low_flag;
		logic low_irq_en;
		logic split;
		logic run;
		logic ext_clk;
	} art_ctrl_t;

	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} art_sfr_req_t;
endpackage : art_pkg

//--- verilog/art_tick_div.sv
`timescale 1ns/1ps
// Produces a one-cycle tick every RATIO qualifying input events
module art_tick_div #(
	parameter int RATIO = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic event_in,
	output logic tick
);
	localparam int CW = $clog2(RATIO);
	localparam logic [CW-1:0] LAST = CW'(RATIO - 1);
	localparam logic [CW-1:0] ONE = CW'(1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic tick_d;

	always_comb begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (event_in) begin
			if (cnt_q == LAST) begin
				cnt_d = '0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + ONE;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= tick_d;
		end
	end
endmodule : art_tick_div

//--- verilog/art_timer.sv
`timescale 1ns/1ps
// Operation
// - Timer is a low and a high count byte; split bit picks 16-bit or two 8-bit.
// - 16-bit mode counts up; on FFFF to 0000 reload both bytes, set high flag.
// - Every high-flag overflow requests an interrupt while timer irq enable is set.
// - 16-bit mode: low byte rollover also interrupts if low irq enable set.
// - Split mode: each byte auto-reloads from its own reload byte.
// - Split mode: run bit gates only high byte; 16-bit mode: whole timer.
// - Byte clock: select bit set gives core clock, else core/12 or external/8; 16-bit mode uses the low select bit only.
// - External clock is synchronised to core clock, then divided by 8 before counting.
// - Split mode: high and low rollovers set high and low flags.
// - Split mode interrupts on high overflow, or either byte with low irq enable.
// - Overflow flags are cleared only by reset or a software write of zero.
// - Control bits: 7 high flag, 6 low flag, 5 low irq en, 3 split, 2 run, 0 ext.
module art_timer
	import art_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input art_sfr_req_t sfr_req,
	input wire logic timer_irq_enable_bit,
	input wire logic ext_osc,
	output logic [7:0] sfr_rdata,
	output logic timer_irq,
	output logic high_overflow_pulse,
	output logic low_overflow_pulse
);
	////////////////////////////////////////////////////////////////////////////////
	// External oscillator synchroniser and edge detect

	logic ext_meta_q;
	logic ext_sync_q;
	logic ext_prev_q;
	logic ext_rise;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_meta_q <= ext_osc;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_sync_q;
		end
	end

	assign ext_rise = ext_sync_q & ~ext_prev_q;

	////////////////////////////////////////////////////////////////////////////////
	// Prescalers

	logic core_div_tick;
	logic ext_div_tick;

	art_tick_div #(
		.RATIO(ART_CORE_DIV)
	) u_core_div (
		.clk(clk),
		.rst(rst),
		.event_in(1'b1),
		.tick(core_div_tick)
	);

	art_tick_div #(
		.RATIO(ART_EXT_DIV)
	) u_ext_div (
		.clk(clk),
		.rst(rst),
		.event_in(ext_rise),
		.tick(ext_div_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	art_ctrl_t ctrl_q;
	art_ctrl_t ctrl_d;
	logic [7:0] clksel_q;
	logic [7:0] clksel_d;
	logic [7:0] reload_low_q;
	logic [7:0] reload_low_d;
	logic [7:0] reload_high_q;
	logic [7:0] reload_high_d;
	logic [7:0] count_low_q;
	logic [7:0] count_low_d;
	logic [7:0] count_high_q;
	logic [7:0] count_high_d;
	logic [7:0] rdata_d;
	logic irq_d;
	logic high_pulse_d;
	logic low_pulse_d;

	logic high_clk_sel;
	logic low_clk_sel;
	logic slow_tick;
	logic low_tick;
	logic high_tick;
	logic low_run;
	logic high_run;
	logic low_wrap;
	logic high_wrap;
	logic wr_ctrl;
	logic [7:0] ctrl_byte;

	assign high_clk_sel = clksel_q[ART_BIT_HIGH_CLK_SEL];
	assign low_clk_sel = clksel_q[ART_BIT_LOW_CLK_SEL];
	assign slow_tick = ctrl_q.ext_clk ? ext_div_tick : core_div_tick;

	// Clock enable for each byte
	always_comb begin
		low_tick = low_clk_sel ? 1'b1 : slow_tick;
		// Outside split mode the whole word uses the low-byte clock
		if (ctrl_q.split) begin
			high_tick = high_clk_sel ? 1'b1 : slow_tick;
		end else begin
			high_tick = low_tick;
		end
		low_run = ctrl_q.split ? 1'b1 : ctrl_q.run;
		high_run = ctrl_q.run;
	end

	// Packed control byte, reserved bits read zero
	always_comb begin
		ctrl_byte = ART_RESET_BYTE;
		ctrl_byte[ART_BIT_HIGH_FLAG] = ctrl_q.high_flag;
		ctrl_byte[ART_BIT_LOW_FLAG] = ctrl_q.low_flag;
		ctrl_byte[ART_BIT_LOW_IRQ_EN] = ctrl_q.low_irq_en;
		ctrl_byte[ART_BIT_SPLIT] = ctrl_q.split;
		ctrl_byte[ART_BIT_RUN] = ctrl_q.run;
		ctrl_byte[ART_BIT_EXT_CLK] = ctrl_q.ext_clk;
	end

	assign wr_ctrl = sfr_req.write && (sfr_req.addr == ART_ADDR_CONTROL);

	// Counting, reload, flags and software writes
	always_comb begin
		count_low_d = count_low_q;
		count_high_d = count_high_q;
		low_wrap = 1'b0;
		high_wrap = 1'b0;
		if (ctrl_q.split) begin
			if (low_run && low_tick) begin
				if (count_low_q == ART_BYTE_MAX) begin
					count_low_d = reload_low_q;
					low_wrap = 1'b1;
				end else begin
					count_low_d = count_low_q + 8'h01;
				end
			end
			if (high_run && high_tick) begin
				if (count_high_q == ART_BYTE_MAX) begin
					count_high_d = reload_high_q;
					high_wrap = 1'b1;
				end else begin
					count_high_d = count_high_q + 8'h01;
				end
			end
		end else if (high_run && low_tick) begin
			if (count_low_q == ART_BYTE_MAX) begin
				low_wrap = 1'b1;
				if (count_high_q == ART_BYTE_MAX) begin
					count_low_d = reload_low_q;
					count_high_d = reload_high_q;
					high_wrap = 1'b1;
				end else begin
					count_low_d = 8'h00;
					count_high_d = count_high_q + 8'h01;
				end
			end else begin
				count_low_d = count_low_q + 8'h01;
			end
		end

		ctrl_d = ctrl_q;
		clksel_d = clksel_q;
		reload_low_d = reload_low_q;
		reload_high_d = reload_high_q;
		if (sfr_req.write) begin
			case (sfr_req.addr)
				ART_ADDR_CLOCK_SELECT: clksel_d = sfr_req.wdata;
				ART_ADDR_RELOAD_LOW: reload_low_d = sfr_req.wdata;
				ART_ADDR_RELOAD_HIGH: reload_high_d = sfr_req.wdata;
				ART_ADDR_COUNT_LOW: count_low_d = sfr_req.wdata;
				ART_ADDR_COUNT_HIGH: count_high_d = sfr_req.wdata;
				default: ;
			endcase
		end
		if (wr_ctrl) begin
			ctrl_d.high_flag = sfr_req.wdata[ART_BIT_HIGH_FLAG];
			ctrl_d.low_flag = sfr_req.wdata[ART_BIT_LOW_FLAG];
			ctrl_d.low_irq_en = sfr_req.wdata[ART_BIT_LOW_IRQ_EN];
			ctrl_d.split = sfr_req.wdata[ART_BIT_SPLIT];
			ctrl_d.run = sfr_req.wdata[ART_BIT_RUN];
			ctrl_d.ext_clk = sfr_req.wdata[ART_BIT_EXT_CLK];
		end
		// Hardware set wins over a software clear in the same cycle
		if (high_wrap) begin
			ctrl_d.high_flag = 1'b1;
		end
		if (low_wrap) begin
			ctrl_d.low_flag = 1'b1;
		end

		high_pulse_d = high_wrap;
		low_pulse_d = low_wrap;
		irq_d = timer_irq_enable_bit
			&& (high_wrap || (low_wrap && ctrl_q.low_irq_en));

		rdata_d = ART_RESET_BYTE;
		if (sfr_req.read) begin
			case (sfr_req.addr)
				ART_ADDR_CLOCK_SELECT: rdata_d = clksel_q;
				ART_ADDR_CONTROL: rdata_d = ctrl_byte;
				ART_ADDR_RELOAD_LOW: rdata_d = reload_low_q;
				ART_ADDR_RELOAD_HIGH: rdata_d = reload_high_q;
				ART_ADDR_COUNT_LOW: rdata_d = count_low_q;
				ART_ADDR_COUNT_HIGH: rdata_d = count_high_q;
				default: rdata_d = ART_RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= '0;
			clksel_q <= ART_RESET_BYTE;
			reload_low_q <= ART_RESET_BYTE;
			reload_high_q <= ART_RESET_BYTE;
			count_low_q <= ART_RESET_BYTE;
			count_high_q <= ART_RESET_BYTE;
			sfr_rdata <= ART_RESET_BYTE;
			timer_irq <= 1'b0;
			high_overflow_pulse <= 1'b0;
			low_overflow_pulse <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			clksel_q <= clksel_d;
			reload_low_q <= reload_low_d;
			reload_high_q <= reload_high_d;
			count_low_q <= count_low_d;
			count_high_q <= count_high_d;
			sfr_rdata <= rdata_d;
			timer_irq <= irq_d;
			high_overflow_pulse <= high_pulse_d;
			low_overflow_pulse <= low_pulse_d;
		end
	end
endmodule : art_timer

//--- test/art_timer_props.sv
`timescale 1ns/1ps
module art_timer_props
	import art_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input art_sfr_req_t sfr_req,
	input wire logic timer_irq_enable_bit,
	input wire logic [7:0] sfr_rdata,
	input wire logic timer_irq,
	input wire logic high_overflow_pulse,
	input wire logic low_overflow_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic rd_ctrl = sfr_req.read && sfr_req.addr == ART_ADDR_CONTROL;
	////////////////////////////////////////
	property p_cause; timer_irq |-> high_overflow_pulse || low_overflow_pulse; endproperty
	a_cause: assert property (p_cause) else $error("irq without overflow");
	property p_high; high_overflow_pulse && timer_irq_enable_bit && $stable(timer_irq_enable_bit) |-> timer_irq; endproperty
	a_high: assert property (p_high) else $error("high overflow without irq");
	property p_off; !timer_irq_enable_bit && $stable(timer_irq_enable_bit) |-> !timer_irq; endproperty
	a_off: assert property (p_off) else $error("irq while disabled");
	property p_idle; !$past(sfr_req.read) |-> sfr_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_unused; rd_ctrl |=> !sfr_rdata[4] && !sfr_rdata[1]; endproperty
	a_unused: assert property (p_unused) else $error("unused control bit set");
	property p_reset; $fell(rst) |-> sfr_rdata == 8'h00 && !timer_irq && !high_overflow_pulse; endproperty
	a_reset: assert property (p_reset) else $error("output active after reset");
	property p_hflag; high_overflow_pulse && rd_ctrl |=> sfr_rdata[7]; endproperty
	a_hflag: assert property (p_hflag) else $error("high flag not set");
	property p_lflag; low_overflow_pulse && rd_ctrl |=> sfr_rdata[6]; endproperty
	a_lflag: assert property (p_lflag) else $error("low flag not set");
	c_high: cover property (high_overflow_pulse && timer_irq);
	c_low: cover property (low_overflow_pulse && !high_overflow_pulse && timer_irq);
	c_rd: cover property (rd_ctrl ##1 sfr_rdata[6]);
endmodule : art_timer_props
bind art_timer art_timer_props u_props (.clk(clk), .rst(rst), .sfr_req(sfr_req),
	.timer_irq_enable_bit(timer_irq_enable_bit), .sfr_rdata(sfr_rdata), .timer_irq(timer_irq),
	.high_overflow_pulse(high_overflow_pulse), .low_overflow_pulse(low_overflow_pulse));

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import art_pkg::*;
;
	logic clk = 0;
	logic rst = 1;
	logic en = 0;
	logic ext = 0;
	art_sfr_req_t req = '0;
	logic [7:0] rdata;
	logic irq, hp, lp;
	int n_errors = 0;
	int checks = 0;
	logic [7:0] regs [7] = '{ART_ADDR_CONTROL, ART_ADDR_CLOCK_SELECT, ART_ADDR_RELOAD_LOW, ART_ADDR_RELOAD_HIGH,
		ART_ADDR_COUNT_LOW, ART_ADDR_COUNT_HIGH, 8'h5A};
	always #4 clk = ~clk;
	// Free-running oscillator, unrelated in phase to clk
	always #17 ext = ~ext;
	art_timer dut (.clk(clk), .rst(rst), .sfr_req(req), .timer_irq_enable_bit(en), .ext_osc(ext),
		.sfr_rdata(rdata), .timer_irq(irq), .high_overflow_pulse(hp), .low_overflow_pulse(lp));
	////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		req = '{w, !w, a, d};
		@(negedge clk);
		q = rdata;
		req = '0;
		@(negedge clk);
	endtask : acc
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string what);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, q);
		chk(what, 16'(e), 16'(q));
	endtask : rc
	task automatic cfg(input logic [7:0] v [6]);
		logic [7:0] q;
		foreach (v[j]) acc(1'b1, regs[j], v[j], q);
	endtask : cfg
	task automatic wpulse(input logic hi, output int c);
		c = 0;
		while ((hi ? hp : lp) !== 1'b1 && c < 9000) begin
			@(negedge clk);
			c++;
		end
		chk("pulse", 16'h0001, 16'(c < 9000));
	endtask : wpulse
	task automatic close_out();
		$display("n_errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	initial begin
		#100us;
		n_errors++;
		close_out();
	end
	initial begin
		logic [7:0] q, rl, rh, cn;
		int c, p;
		void'($urandom(32'hE004));
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		foreach (regs[i]) rc(regs[i], 8'h00, "reset value");
		foreach (regs[i]) begin
			rh = 8'($urandom) & (i == 0 ? 8'hF3 : 8'hFF);
			acc(1'b1, regs[i], rh, q);
			rc(regs[i], i == 6 ? 8'h00 : (i == 0 ? rh & ART_CONTROL_WRITE_MASK : rh), "readback");
		end
		// Core clock, core/12 and external/8 over a 16-tick reload span
		for (int i = 0; i < 3; i++) begin
			en = (i != 1);
			cn = i == 2 ? 8'h05 : 8'h04;
			p = i == 0 ? 16 : (i == 1 ? 16 * ART_CORE_DIV : 544);
			cfg('{8'h00, i == 0 ? 8'h10 : 8'h00, 8'hF0, 8'hFF, 8'hF0, 8'hFF});
			acc(1'b1, ART_ADDR_CONTROL, cn, q);
			wpulse(1'b1, c);
			@(negedge clk);
			wpulse(1'b1, c);
			chk("period", 16'h0001, 16'((c + 1 - p) * (c + 1 - p) <= (i == 2 ? 1 : 0)));
			chk("irq", 16'(en), 16'(irq));
			rc(ART_ADDR_CONTROL, cn | 8'hC0, "flags");
			acc(1'b1, ART_ADDR_CONTROL, 8'h00, q);
			rc(ART_ADDR_CONTROL, 8'h00, "flags cleared");
			acc(1'b0, ART_ADDR_COUNT_LOW, 8'h00, q);
			rc(ART_ADDR_COUNT_LOW, q, "stopped low");
			rc(ART_ADDR_COUNT_HIGH, 8'hFF, "reload high");
		end
		for (int k = 0; k < 2; k++) begin
			cfg('{8'h00, 8'h10, 8'h00, 8'h00, 8'hFE, 8'h00});
			acc(1'b1, ART_ADDR_CONTROL, k ? 8'h24 : 8'h04, q);
			wpulse(1'b0, c);
			chk("low irq", 16'(2 * k), 16'({irq, hp}));
		end
		rl = 8'($urandom);
		rh = 8'($urandom);
		cfg('{8'h00, 8'h30, rl, rh, 8'hFD, 8'hFD});
		acc(1'b1, ART_ADDR_CONTROL, 8'h28, q);
		wpulse(1'b0, c);
		chk("split low irq", 16'h0001, 16'(irq));
		rc(ART_ADDR_COUNT_HIGH, 8'hFD, "high held");
		acc(1'b0, ART_ADDR_COUNT_LOW, 8'h00, q);
		chk("low reload", 16'h0001, 16'(8'(q - rl) <= 8));
		rc(ART_ADDR_CONTROL, 8'h68, "low flag");
		acc(1'b1, ART_ADDR_CONTROL, 8'h2C, q);
		wpulse(1'b1, c);
		chk("split high irq", 16'h0001, 16'(irq));
		acc(1'b0, ART_ADDR_CONTROL, 8'h00, q);
		chk("high flag", 16'h0001, 16'(q[7]));
		close_out();
	end
endmodule : tb_top
